// ===== core/iobl_cfg.svh
// constants for the buffer lockout block: offsets, fields, reset values
`ifndef IOBL_CFG_SVH
`define IOBL_CFG_SVH

`define IOBL_NARROW_W 8
`define IOBL_WIDE_W 36
`define IOBL_NLINES 4
`define IOBL_ADDR_W 15
`define IOBL_INTR_LOC 15'h00F3
`define IOBL_SEL_INTR_BIT 32

`define IOBL_OFF_STATUS 12'h000
`define IOBL_OFF_MASK 12'h004
`define IOBL_OFF_INTEN 12'h008
`define IOBL_OFF_STATE 12'h00C
`define IOBL_OFF_NBUF 12'h010
`define IOBL_OFF_WBUF 12'h014
`define IOBL_OFF_WBUFH 12'h018
`define IOBL_OFF_EFEN 12'h01C

`define IOBL_ST_W 5
`define IOBL_ST_NF1 0
`define IOBL_ST_NF2 1
`define IOBL_ST_WF1 2
`define IOBL_ST_WF2 3
`define IOBL_ST_INT 4
`define IOBL_FLT_W 4

`define IOBL_STATUS_RST 5'h00
`define IOBL_MASK_RST 5'h00

`endif

// ===== core/iobl_pkg.sv
// types shared by the buffer lockout block
package iobl_pkg;
	typedef enum logic [1:0] {IOBL_OP_OUT, IOBL_OP_IN, IOBL_OP_EFN} iobl_op_t;
	typedef enum logic {IOBL_RUN, IOBL_SUSP} iobl_seq_t;
endpackage

// ===== core/iobl_buf_if.sv
// carrier between the top and one buffer controller
`timescale 1ns/1ps
`default_nettype none
interface iobl_buf_if #(parameter int W = 8) ();
	logic op_req;
	logic op_is_in;
	logic [W-1:0] op_wdata;
	logic op_done;
	logic eq_resume;
	logic eq_load;
	logic [W-1:0] eq_data;
	logic [W-1:0] contents;
	logic lock_est;
	logic out_pend;
	logic in_wait;
	logic fault1;
	logic fault2;
	modport ctl (input op_req, op_is_in, op_wdata, eq_resume, eq_load,
		eq_data, output op_done, contents, lock_est, out_pend, in_wait,
		fault1, fault2);
	modport top (output op_req, op_is_in, op_wdata, eq_resume, eq_load,
		eq_data, input op_done, contents, lock_est, out_pend, in_wait,
		fault1, fault2);
endinterface
`default_nettype wire

// ===== core/iobl_buf_ctl.sv
// lockout and read-fault control for one general buffer
`timescale 1ns/1ps
`default_nettype none
module iobl_buf_ctl #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// link to top
	iobl_buf_if.ctl bi
);
	if (W < 1) begin : g_chk
		$error("buffer width must be at least one");
	end

	logic [W-1:0] buf_q;
	logic out_pend_q;
	logic data_ok_q;
	logic lock_q;
	logic take_out;
	logic take_in;

	// resume in the same cycle frees the buffer for the new word
	assign take_out = bi.op_req & ~bi.op_is_in & (~out_pend_q | bi.eq_resume);
	assign take_in = bi.op_req & bi.op_is_in & data_ok_q;
	assign bi.op_done = take_out | take_in;
	assign bi.contents = buf_q;
	assign bi.lock_est = lock_q;
	assign bi.out_pend = out_pend_q;
	assign bi.in_wait = ~data_ok_q;
	assign bi.fault1 = bi.eq_load & data_ok_q & ~take_in;
	assign bi.fault2 = bi.eq_load & out_pend_q & ~bi.eq_resume;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			buf_q <= '0;
		end else begin
			if (bi.eq_resume) begin
				buf_q <= '0;
			end
			if (take_in) begin
				buf_q <= '0;
			end
			if (bi.eq_load) begin
				buf_q <= bi.eq_data;
			end
			if (take_out) begin
				buf_q <= bi.op_wdata;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			out_pend_q <= 1'b0;
		end else if (take_out) begin
			out_pend_q <= 1'b1;
		end else if (bi.eq_resume) begin
			out_pend_q <= 1'b0;
		end
	end

	// load wins over a take in the same cycle so no word is lost
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			data_ok_q <= 1'b0;
		end else if (bi.eq_load) begin
			data_ok_q <= 1'b1;
		end else if (take_in) begin
			data_ok_q <= 1'b0;
		end
	end

	// established lockout holds the sequencer at the test step
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			lock_q <= 1'b0;
		end else begin
			lock_q <= bi.op_req & ~bi.op_done;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	resume_clears_a: assert property (
		bi.eq_resume & ~take_out & ~bi.eq_load & ~take_in
		|=> buf_q == '0 && !out_pend_q)
		else $error("resume did not clear buffer");
	out_word_taken_a: assert property (
		take_out |=> buf_q == $past(bi.op_wdata) && out_pend_q)
		else $error("output word not accepted");
	out_lockout_a: assert property (
		bi.op_req & ~bi.op_is_in & out_pend_q & ~bi.eq_resume
		|-> !bi.op_done ##1 lock_q)
		else $error("second output not locked out");
	in_lockout_a: assert property (
		bi.op_req & bi.op_is_in & ~data_ok_q |-> !bi.op_done ##1 lock_q)
		else $error("input without data not locked out");
	in_sequence_a: assert property (
		take_in & ~bi.eq_load |=> buf_q == '0 && !data_ok_q)
		else $error("input did not clear and rearm");
	load_releases_a: assert property (
		bi.eq_load & bi.op_req & bi.op_is_in & ~data_ok_q
		##1 bi.op_req |-> bi.op_done)
		else $error("data arrival did not release lockout");
	lock_cover: cover property (lock_q ##1 bi.op_done);
	fault_cover: cover property (bi.fault1 || bi.fault2);
endmodule // iobl_buf_ctl
`default_nettype wire

// ===== core/iobl_top.sv
// general buffer lockout, read-fault and program interrupt control
//
// Overview of operation
// - narrow buffer 8 bits, wide 36 bits
// - output waits until buffer reported cleared
// - resume clears buffer and lockout
// - second output before resume establishes lockout
// - halt at test, continue on resume
// - input stalls until data arrived
// - data arrival cancels or releases lockout
// - input: test, copy, clear, initiate, store
// - early data lets input run unstalled
// - input without data establishes lockout
// - read faults halt, never lock out
// - each fault own flag plus combined
// - second data before take is class one
// - data during pending output is class two
// - interrupt suspends and fetches fixed location
// - interrupt line acts only when enabled
`include "iobl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module iobl_top import iobl_pkg::*; #(
	parameter int NW = `IOBL_NARROW_W,
	parameter int WW = `IOBL_WIDE_W,
	parameter int NL = `IOBL_NLINES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// instruction sequencer
	input wire logic op_req,
	input wire iobl_op_t op_kind,
	input wire logic op_wide,
	input wire logic [WW-1:0] op_wdata,
	output logic op_done,
	output logic [WW-1:0] op_rdata,
	output logic lockout,
	output logic intr_suspend,
	output logic [`IOBL_ADDR_W-1:0] intr_addr,
	input wire logic intr_ack,
	// fault indicators
	output logic [`IOBL_FLT_W-1:0] fault_ind,
	output logic iofault_halt,
	// narrow buffer equipment side
	input wire logic nar_resume,
	input wire logic nar_load,
	input wire logic [NW-1:0] nar_data,
	output logic [NW-1:0] nar_contents,
	// wide buffer equipment side
	input wire logic wid_resume,
	input wire logic wid_load,
	input wire logic [WW-1:0] wid_data,
	output logic [WW-1:0] wid_contents,
	output logic efn_strobe,
	// equipment interrupt lines
	input wire logic [NL-1:0] eq_intr,
	input wire logic [NL-1:0] eq_intr_switch,
	// interrupt to host
	output logic irq
);
	// select-interrupt bit and line enables must fit in the wide buffer
	if (NW < 1 || NW > WW || WW <= `IOBL_SEL_INTR_BIT || WW > 64
		|| NL < 1 || NL > `IOBL_SEL_INTR_BIT) begin : g_chk
		$error("unsupported buffer or line widths");
	end

	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] off);
		return a == off;
	endfunction

	iobl_buf_if #(.W(NW)) nb ();
	iobl_buf_if #(.W(WW)) wb ();

	logic [`IOBL_ST_W-1:0] stat_q;
	logic [`IOBL_ST_W-1:0] stat_set;
	logic [`IOBL_ST_W-1:0] mask_q;
	logic [NL-1:0] inten_q;
	logic [NL-1:0] efen_q;
	logic [NL-1:0] line_en;
	logic [31:0] prdata_q;
	logic [31:0] rd_d;
	logic [WW-1:0] x_q;
	logic [`IOBL_ADDR_W-1:0] iaddr_q;
	logic efn_q;
	logic is_wide;
	logic halt;
	logic wr;
	logic map_hit;
	logic intr_go;
	iobl_seq_t seq_q;

	// buffers the sequencer addresses; function command always uses wide
	assign is_wide = op_wide | (op_kind == IOBL_OP_EFN);
	assign halt = |stat_q[`IOBL_FLT_W-1:0];

	// a fault halts computation: no request reaches either buffer
	always_comb begin
		nb.op_req = op_req & ~halt & ~is_wide;
		nb.op_is_in = op_kind == IOBL_OP_IN;
		nb.op_wdata = op_wdata[NW-1:0];
		nb.eq_resume = nar_resume;
		nb.eq_load = nar_load;
		nb.eq_data = nar_data;
		wb.op_req = op_req & ~halt & is_wide;
		wb.op_is_in = op_kind == IOBL_OP_IN;
		wb.op_wdata = op_wdata;
		wb.eq_resume = wid_resume;
		wb.eq_load = wid_load;
		wb.eq_data = wid_data;
	end

	iobl_buf_ctl #(.W(NW)) u_nar (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.bi(nb)
	);

	iobl_buf_ctl #(.W(WW)) u_wid (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.bi(wb)
	);

	assign op_done = nb.op_done | wb.op_done;
	assign lockout = nb.lock_est | wb.lock_est;
	assign nar_contents = nb.contents;
	assign wid_contents = wb.contents;

	// transfer register: copy taken before the buffer is cleared
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			x_q <= '0;
		end else if (nb.op_done & nb.op_is_in) begin
			x_q <= WW'(nb.contents);
		end else if (wb.op_done & wb.op_is_in) begin
			x_q <= wb.contents;
		end
	end
	assign op_rdata = x_q;

	// function command strobe tells equipment to decode the wide buffer
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			efn_q <= 1'b0;
		end else begin
			efn_q <= wb.op_done & (op_kind == IOBL_OP_EFN);
		end
	end
	assign efn_strobe = efn_q;

	// select-interrupt bit enables the lines named in the low bits
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			efen_q <= '0;
		end else if (wb.op_done & (op_kind == IOBL_OP_EFN)
			& op_wdata[`IOBL_SEL_INTR_BIT]) begin
			efen_q <= efen_q | op_wdata[NL-1:0];
		end
	end

	assign line_en = eq_intr_switch | efen_q | inten_q;
	// suspend only between instructions, never while one is in flight
	assign intr_go = |(eq_intr & line_en) & ~op_req & ~halt;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			seq_q <= IOBL_RUN;
		end else begin
			case (seq_q)
				IOBL_RUN: begin
					if (intr_go) begin
						seq_q <= IOBL_SUSP;
					end
				end
				IOBL_SUSP: begin
					if (intr_ack) begin
						seq_q <= IOBL_RUN;
					end
				end
				default: begin
					seq_q <= IOBL_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			iaddr_q <= '0;
		end else if (seq_q == IOBL_RUN && intr_go) begin
			iaddr_q <= `IOBL_INTR_LOC;
		end
	end
	assign intr_suspend = seq_q == IOBL_SUSP;
	assign intr_addr = iaddr_q;

	// sticky events; a set in the clearing cycle survives
	always_comb begin
		stat_set = '0;
		stat_set[`IOBL_ST_NF1] = nb.fault1;
		stat_set[`IOBL_ST_NF2] = nb.fault2;
		stat_set[`IOBL_ST_WF1] = wb.fault1;
		stat_set[`IOBL_ST_WF2] = wb.fault2;
		stat_set[`IOBL_ST_INT] = seq_q == IOBL_RUN && intr_go;
	end

	assign wr = psel & penable & pwrite;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			stat_q <= `IOBL_STATUS_RST;
		end else if (wr && hit(paddr, `IOBL_OFF_STATUS)) begin
			stat_q <= (stat_q & ~pwdata[`IOBL_ST_W-1:0]) | stat_set;
		end else begin
			stat_q <= stat_q | stat_set;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			mask_q <= `IOBL_MASK_RST;
		end else if (wr && hit(paddr, `IOBL_OFF_MASK)) begin
			mask_q <= pwdata[`IOBL_ST_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			inten_q <= '0;
		end else if (wr && hit(paddr, `IOBL_OFF_INTEN)) begin
			inten_q <= pwdata[NL-1:0];
		end
	end

	// each fault has its own lamp and feeds the combined class-B lamp
	assign fault_ind = stat_q[`IOBL_FLT_W-1:0];
	assign iofault_halt = halt;
	assign irq = |(stat_q & mask_q);

	always_comb begin
		map_hit = 1'b1;
		rd_d = '0;
		case (paddr)
			`IOBL_OFF_STATUS: rd_d = 32'(stat_q);
			`IOBL_OFF_MASK: rd_d = 32'(mask_q);
			`IOBL_OFF_INTEN: rd_d = 32'(inten_q);
			`IOBL_OFF_STATE: rd_d = 32'({wb.in_wait, wb.out_pend,
				wb.lock_est, nb.in_wait, nb.out_pend, nb.lock_est,
				intr_suspend});
			`IOBL_OFF_NBUF: rd_d = 32'(nb.contents);
			`IOBL_OFF_WBUF: rd_d = wb.contents[31:0];
			`IOBL_OFF_WBUFH: rd_d = 32'(wb.contents[WW-1:32]);
			`IOBL_OFF_EFEN: rd_d = 32'(efen_q);
			default: map_hit = 1'b0;
		endcase
	end

	// read data captured in the setup cycle so pready can stay high
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			prdata_q <= '0;
		end else if (psel & ~penable & ~pwrite) begin
			prdata_q <= rd_d;
		end
	end
	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~map_hit;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	nar_fault_flag_a: assert property (
		nb.fault1 |=> stat_q[`IOBL_ST_NF1] && iofault_halt)
		else $error("narrow class one fault not flagged");
	wid_fault_two_a: assert property (
		wid_load & wb.out_pend & ~wid_resume |=> fault_ind[`IOBL_ST_WF2])
		else $error("wide class two fault not flagged");
	nar_fault_one_a: assert property (
		nar_load & ~nb.in_wait & ~nb.op_done |=> fault_ind[`IOBL_ST_NF1])
		else $error("narrow class one fault missed");
	halt_blocks_a: assert property (
		iofault_halt |-> !op_done && !$rose(lockout))
		else $error("buffer acted while halted");
	intr_take_a: assert property (
		!intr_suspend && intr_go |=> intr_suspend
		&& intr_addr == `IOBL_INTR_LOC && stat_q[`IOBL_ST_INT])
		else $error("interrupt not taken");
	intr_gate_a: assert property (
		!intr_suspend && !(|(eq_intr & line_en)) |=> !intr_suspend)
		else $error("disabled line caused suspend");
	reset_clear_a: assert property (
		@(posedge sys_clk) disable iff (1'b0)
		!resetn |=> stat_q == '0 && !lockout
		&& nar_contents == '0 && wid_contents == '0)
		else $error("reset left state behind");
	in_copy_a: assert property (
		nb.op_done & nb.op_is_in & ~nar_load
		|=> op_rdata == WW'($past(nar_contents)) && nar_contents == '0)
		else $error("input copy wrong");
	intr_cover: cover property (intr_suspend ##1 !intr_suspend);
	fault_two_cover: cover property ($rose(fault_ind[`IOBL_ST_NF2]));
	apb_err_cover: cover property (pslverr);
endmodule // iobl_top
`default_nettype wire

// ===== tb/iobl_eq_model.sv
// equipment-side model: senses output words and delivers input words
`timescale 1ns/1ps
`default_nettype none
module iobl_eq_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// bench commands, bit 1 wide, bit 0 narrow
	input wire logic [1:0] sense_req,
	input wire logic [1:0] load_req,
	input wire logic [35:0] load_word,
	input wire logic [3:0] dly,
	// equipment lines
	output logic nar_resume,
	output logic nar_load,
	output logic [7:0] nar_data,
	output logic wid_resume,
	output logic wid_load,
	output logic [35:0] wid_data
);
	logic pend_q;
	logic is_load_q;
	logic is_wide_q;
	logic [3:0] cnt_q;
	logic [35:0] word_q;
	always_ff @(posedge sys_clk) begin
		nar_resume <= 1'b0;
		wid_resume <= 1'b0;
		nar_load <= 1'b0;
		wid_load <= 1'b0;
		// idle lines toggle so a stale word never passes for a fresh one
		nar_data <= ~nar_data;
		wid_data <= ~wid_data;
		if (!resetn) begin
			pend_q <= 1'b0;
			cnt_q <= 4'h0;
			nar_data <= 8'h00;
			wid_data <= 36'h0;
		end else if (!pend_q && (sense_req != 2'h0 || load_req != 2'h0)) begin
			pend_q <= 1'b1;
			cnt_q <= dly;
			is_load_q <= (load_req != 2'h0);
			is_wide_q <= sense_req[1] | load_req[1];
			word_q <= load_word;
		end else if (pend_q && cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end else if (pend_q) begin
			pend_q <= 1'b0;
			if (!is_load_q) begin
				nar_resume <= !is_wide_q;
				wid_resume <= is_wide_q;
			end else if (is_wide_q) begin
				wid_load <= 1'b1;
				wid_data <= word_q;
			end else begin
				nar_load <= 1'b1;
				nar_data <= word_q[7:0];
			end
		end
	end
endmodule // iobl_eq_model
`default_nettype wire

// ===== tb/io_buffer_lockout_control_tb.sv
// self-checking bench for the buffer lockout block
`timescale 1ns/1ps
`default_nettype none
module io_buffer_lockout_control_tb import iobl_pkg::*;;
	logic sys_clk = 1'b0, resetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, op_req = 1'b0, op_wide = 1'b0, op_done, er, lk;
	iobl_op_t op_kind = IOBL_OP_OUT;
	logic [35:0] op_wdata = 36'h0, op_rdata, wid_data, wid_contents, d, d2;
	logic [35:0] load_word = 36'h0;
	logic lockout, intr_suspend, intr_ack = 1'b0, iofault_halt, irq;
	logic [14:0] intr_addr;
	logic [3:0] fault_ind, dly = 4'h0;
	logic [3:0] eq_intr = 4'h0, eq_intr_switch = 4'h0;
	logic nar_resume, nar_load, wid_resume, wid_load, efn_strobe;
	logic [7:0] nar_data, nar_contents;
	logic [1:0] sense_req = 2'h0, load_req = 2'h0;
	int num_errors = 0, samples_checked = 0, cyc = 0, c, i;

	iobl_top u_dut (.sys_clk, .resetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .op_req, .op_kind, .op_wide,
		.op_wdata, .op_done, .op_rdata, .lockout, .intr_suspend, .intr_addr,
		.intr_ack, .fault_ind, .iofault_halt, .nar_resume, .nar_load,
		.nar_data, .nar_contents, .wid_resume, .wid_load, .wid_data,
		.wid_contents, .efn_strobe, .eq_intr, .eq_intr_switch, .irq);
	iobl_eq_model u_eq (.sys_clk, .resetn, .sense_req, .load_req,
		.load_word, .dly, .nar_resume, .nar_load, .nar_data, .wid_resume,
		.wid_load, .wid_data);

	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [35:0] s, input logic [35:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	// fault lamp order: narrow class one, narrow two, wide one, wide two
	function automatic logic [3:0] flt_bit(input logic wide,
			input logic cls2);
		return 4'h1 << {wide, cls2};
	endfunction
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ld: deliver a word, else sense and resume; w: wide buffer
	task automatic eq(input logic ld, input logic w, input logic [35:0] wd);
		@(posedge sys_clk);
		sense_req <= ld ? 2'h0 : {w, !w};
		load_req <= ld ? {w, !w} : 2'h0;
		load_word <= wd;
		@(posedge sys_clk);
		sense_req <= 2'h0;
		load_req <= 2'h0;
		repeat (dly + 2) @(posedge sys_clk);
	endtask
	task automatic op(input iobl_op_t k, input logic w, input logic [35:0] wd);
		@(posedge sys_clk);
		op_req <= 1'b1;
		op_kind <= k;
		op_wide <= w;
		op_wdata <= wd;
		c = 0;
		lk = 1'b0;
		@(negedge sys_clk);
		while (op_done !== 1'b1) begin
			c++;
			@(negedge sys_clk);
			if (c == 1)
				lk = lockout;
		end
		@(posedge sys_clk);
		op_req <= 1'b0;
	endtask

	initial begin
		d = 36'($urandom(32'h5CDC));
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		chk(nar_contents, 8'h00);
		chk(wid_contents, 36'h0);
		chk({lockout, irq, fault_ind}, 36'h0);
		apb(1'b0, 12'hFFC, 32'h0);
		chk({er, r}, {1'b1, 32'h0});
		for (i = 0; i < 4; i++) begin
			dly <= 4'($urandom_range(0, 5));
			d = {4'($urandom), $urandom()};
			d2 = {4'($urandom), $urandom()};
			op(IOBL_OP_OUT, 1'b0, d);
			chk(36'(c), 36'h0);
			@(negedge sys_clk);
			chk(nar_contents, d[7:0]);
			fork
				op(IOBL_OP_OUT, 1'b0, d2);
				eq(1'b0, 1'b0, 36'h0);
			join
			chk(lk, 1'b1);
			@(negedge sys_clk);
			chk(nar_contents, d2[7:0]);
			eq(1'b0, 1'b0, 36'h0);
			eq(1'b1, 1'b0, d);
			op(IOBL_OP_IN, 1'b0, 36'h0);
			chk(36'(c), 36'h0);
			@(negedge sys_clk);
			chk(op_rdata, {28'h0, d[7:0]});
			chk(nar_contents, 36'h0);
			fork
				op(IOBL_OP_IN, 1'b0, 36'h0);
				eq(1'b1, 1'b0, d2);
			join
			chk(lk, 1'b1);
			@(negedge sys_clk);
			chk(op_rdata, {28'h0, d2[7:0]});
		end
		eq(1'b1, 1'b0, d);
		eq(1'b1, 1'b0, d2);
		@(negedge sys_clk);
		chk(fault_ind, flt_bit(1'b0, 1'b0));
		chk({iofault_halt, lockout}, 2'b10);
		@(posedge sys_clk);
		op_req <= 1'b1;
		op_kind <= IOBL_OP_IN;
		op_wide <= 1'b0;
		repeat (3) @(negedge sys_clk);
		chk({op_done, lockout}, 2'b00);
		@(posedge sys_clk);
		op_req <= 1'b0;
		apb(1'b1, 12'h000, 32'h1);
		@(negedge sys_clk);
		chk(fault_ind, 4'h0);
		op(IOBL_OP_IN, 1'b0, 36'h0);
		@(negedge sys_clk);
		chk(op_rdata, {28'h0, d2[7:0]});
		@(posedge sys_clk);
		eq_intr <= 4'h2;
		repeat (3) @(negedge sys_clk);
		chk(intr_suspend, 1'b0);
		apb(1'b1, 12'h004, 32'h1F);
		op(IOBL_OP_EFN, 1'b1, 36'h1_0000_0002);
		@(negedge sys_clk);
		chk(efn_strobe, 1'b1);
		repeat (2) @(negedge sys_clk);
		chk({intr_suspend, intr_addr}, {1'b1, 15'h00F3});
		apb(1'b0, 12'h000, 32'h0);
		chk({irq, r[4]}, 2'b11);
		@(posedge sys_clk);
		eq_intr <= 4'h0;
		intr_ack <= 1'b1;
		@(posedge sys_clk);
		intr_ack <= 1'b0;
		apb(1'b1, 12'h000, 32'h10);
		@(negedge sys_clk);
		chk({intr_suspend, irq}, 2'b00);
		// equipment switch alone enables a line
		@(posedge sys_clk);
		eq_intr_switch <= 4'h4;
		eq_intr <= 4'h4;
		repeat (2) @(negedge sys_clk);
		chk(intr_suspend, 1'b1);
		@(posedge sys_clk);
		eq_intr <= 4'h0;
		intr_ack <= 1'b1;
		@(posedge sys_clk);
		intr_ack <= 1'b0;
		apb(1'b1, 12'h000, 32'h10);
		@(negedge sys_clk);
		chk({intr_suspend, irq}, 2'b00);
		eq(1'b0, 1'b1, 36'h0);
		op(IOBL_OP_OUT, 1'b1, d);
		@(negedge sys_clk);
		chk(wid_contents, d);
		apb(1'b0, 12'h018, 32'h0);
		chk(r, {28'h0, d[35:32]});
		eq(1'b1, 1'b1, d2);
		@(negedge sys_clk);
		chk({irq, fault_ind}, {1'b1, flt_bit(1'b1, 1'b1)});
		apb(1'b1, 12'h000, 32'h8);
		@(negedge sys_clk);
		chk({irq, fault_ind}, 5'h00);
		// mid-run reset with data present, output pending and a fault set
		eq(1'b1, 1'b0, d);
		eq(1'b1, 1'b0, d2);
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		apb(1'b0, 12'h00C, 32'h0);
		chk(r, 32'h48);
		chk({fault_ind, nar_contents}, 12'h000);
		chk(wid_contents, 36'h0);
		test_done();
	end
endmodule // io_buffer_lockout_control_tb
`default_nettype wire
